// ==== verilog/lrxd_pkg.sv ====
`default_nettype none
package lrxd_pkg;

   // ----------------------------------------
   // Sizes and timing
   // ----------------------------------------
   localparam int unsigned WORD_MAX    = 10;
   localparam int unsigned FIFO_DEPTH  = 16;
   localparam int unsigned CLOCK_MHZ   = 100;
   localparam int unsigned SYNC_STAGES = 2;
   localparam logic [3:0]  WIDTH_BAD   = 4'h9;
   localparam logic [3:0]  WIDTH_MAX   = 4'hA;
   localparam logic [3:0]  WIDTH_NARROW_MAX = 4'h2;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic        FLAG_RESET  = 1'h0;
   localparam logic        READY_RESET = 1'h1;
   localparam logic        EMPTY_RESET = 1'h1;
   localparam logic        PWC_RESET   = 1'h0;
   localparam logic [3:0]  PHASE_RESET = 4'h0;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic       des_en;
      logic [3:0] width;
      logic       half_rate;
      logic       dpa;
      logic       fifo_en;
   } lrxd_cfg_t;

   typedef struct packed {
      logic                valid;
      logic [WORD_MAX-1:0] data;
   } lrxd_word_t;

   localparam lrxd_cfg_t CFG_RESET = '{des_en: 1'h1, width: 4'h8,
                                       half_rate: 1'h0, dpa: 1'h0, fifo_en: 1'h1};

   // ----------------------------------------
   // Configuration decoding
   // ----------------------------------------
   // Width in effect: a lane with deserialization off is a one-bit buffer.
   function automatic logic [3:0] lrxd_eff_width(lrxd_cfg_t c);
      return c.des_en ? c.width : 4'h1;
   endfunction

   // Serial clock cycles that make one parallel word.
   function automatic logic [3:0] lrxd_word_cycles(lrxd_cfg_t c);
      return (c.des_en && c.half_rate) ? (c.width >> 1) : lrxd_eff_width(c);
   endfunction

   // Mask that keeps the bits of a word of the width in effect.
   function automatic logic [WORD_MAX-1:0] lrxd_width_mask(lrxd_cfg_t c);
      return WORD_MAX'((11'h001 << lrxd_eff_width(c)) - 11'h001);
   endfunction

   // True when the whole configuration is allowed.
   function automatic logic lrxd_cfg_legal(lrxd_cfg_t c);
      logic ok;
      ok = 1'h1;
      if (c.des_en && (c.width == 4'h0 || c.width > WIDTH_MAX)) ok = 1'h0;
      if (c.des_en && c.width == WIDTH_BAD) ok = 1'h0;
      if (c.half_rate && (!c.des_en || c.width[0])) ok = 1'h0;
      if (c.dpa && c.half_rate) ok = 1'h0;
      if (c.dpa && !c.des_en) ok = 1'h0;
      if (c.dpa && c.width <= WIDTH_NARROW_MAX) ok = 1'h0;
      if (c.fifo_en && (!c.des_en || c.width <= WIDTH_NARROW_MAX)) ok = 1'h0;
      return ok;
   endfunction

endpackage
`default_nettype wire

// ==== verilog/lrxd_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module lrxd_mem #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic                     clock,
   input  wire logic                     rstn,
   input  wire logic                     write_en,
   input  wire logic [$clog2(DEPTH)-1:0] write_addr,
   input  wire logic [WIDTH-1:0]         write_data,
   input  wire logic                     read_en,
   input  wire logic [$clog2(DEPTH)-1:0] read_addr,
   output logic      [WIDTH-1:0]         read_data
);

   logic [WIDTH-1:0] store [DEPTH];

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   // Array write, no reset so it maps onto memory cells.
   always_ff @(posedge clock) begin
      if (write_en) begin
         store[write_addr] <= write_data;
      end
   end

   // Registered read port.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         read_data <= '0;
      end else if (read_en) begin
         read_data <= store[read_addr];
      end
   end

endmodule
`default_nettype wire

// ==== verilog/lrxd_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module lrxd_fifo #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             out_ready,
   output logic                  out_empty,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data
);

   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   count;
   logic [AW:0]   next_count;
   logic          push;
   logic          pop;

   // ----------------------------------------
   // Handshakes
   // ----------------------------------------
   // no empty reads
   // A read while empty is ignored; a write while full is refused.
   assign push = in_valid && in_ready;
   assign pop  = out_ready && !out_empty;

   // Fill level after this cycle.
   always_comb begin
      next_count = count;
      if (push && !pop) next_count = count + (AW+1)'(1);
      if (pop && !push) next_count = count - (AW+1)'(1);
   end

   // Pointers and level.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + AW'(1);
         if (pop) rd_ptr <= rd_ptr + AW'(1);
         count <= next_count;
      end
   end

   // Flags are registered so that they leave the block from flip-flops.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         in_ready  <= lrxd_pkg::READY_RESET;
         out_empty <= lrxd_pkg::EMPTY_RESET;
         out_valid <= lrxd_pkg::FLAG_RESET;
      end else begin
         in_ready  <= next_count != FULL_COUNT;
         out_empty <= next_count == '0;
         out_valid <= pop;
      end
   end

   lrxd_mem #(
      .WIDTH(WIDTH),
      .DEPTH(DEPTH)
   ) u_mem (
      .clock     (clock),
      .rstn      (rstn),
      .write_en  (push),
      .write_addr(wr_ptr),
      .write_data(in_data),
      .read_en   (pop),
      .read_addr (rd_ptr),
      .read_data (out_data)
   );

endmodule
`default_nettype wire

// ==== verilog/lrxd_lane.sv ====
`timescale 1ns/1ps
`default_nettype none
module lrxd_lane #(
   parameter lrxd_pkg::lrxd_cfg_t CFG = lrxd_pkg::CFG_RESET
) (
   input  wire logic              clock,
   input  wire logic              rstn,
   input  wire logic [1:0]        rx_bits,
   input  wire logic              dpa_slip,
   output logic                   parallel_word_clock,
   output lrxd_pkg::lrxd_word_t   word,
   input  wire logic              fifo_read_request,
   output logic                   fifo_empty,
   output lrxd_pkg::lrxd_word_t   fifo_read_word,
   output logic                   lane_ready,
   output logic                   overrun,
   output logic                   cfg_error
);

   // ----------------------------------------
   // Derived settings
   // ----------------------------------------
   localparam logic       CFG_OK   = lrxd_pkg::lrxd_cfg_legal(CFG);
   localparam logic [3:0] CYC      = lrxd_pkg::lrxd_word_cycles(CFG);
   localparam logic [3:0] LAST     = 4'(CYC - 4'h1);
   localparam logic [3:0] PWC_HIGH = 4'((CYC + 4'h1) >> 1);
   localparam logic       HALF     = CFG.des_en && CFG.half_rate;
   localparam logic       DPA_ON   = CFG.dpa && CFG.des_en;
   localparam logic       FIFO_ON  = CFG.fifo_en && CFG_OK;
   localparam logic [lrxd_pkg::WORD_MAX-1:0] MASK = lrxd_pkg::lrxd_width_mask(CFG);

   logic [1:0]                      rx_meta;
   logic [1:0]                      rx_sync;
   logic [3:0]                      phase;
   logic [3:0]                      next_phase;
   logic [lrxd_pkg::WORD_MAX-1:0]   shreg;
   logic [lrxd_pkg::WORD_MAX-1:0]   next_shreg;
   logic                            slip_hold;
   logic                            strobe;
   logic                            fifo_in_ready;
   logic                            fifo_out_valid;
   logic [lrxd_pkg::WORD_MAX-1:0]   fifo_out_data;

   // ----------------------------------------
   // Elaboration check
   // ----------------------------------------
   // reject illegal settings
   generate
      if (!CFG_OK) begin : g_bad_cfg
         $error("lane configuration is not allowed");
      end
   endgenerate

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Each serial pin passes two flip-flops before any logic sees it.
   generate
      for (genvar i = 0; i < 2; i++) begin : g_sync
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               rx_meta[i] <= lrxd_pkg::FLAG_RESET;
               rx_sync[i] <= lrxd_pkg::FLAG_RESET;
            end else begin
               rx_meta[i] <= rx_bits[i];
               rx_sync[i] <= rx_meta[i];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Bit capture
   // ----------------------------------------
   // slip only at full rate
   // A slip request skips one serial bit, moving the word boundary by one.
   assign slip_hold = DPA_ON && !HALF && dpa_slip;

   // serial clock captures
   // Full rate takes one bit per cycle, half rate two, older bit first.
   always_comb begin
      next_shreg = shreg;
      next_phase = phase;
      strobe     = 1'h0;
      if (!slip_hold) begin
         if (HALF) begin
            next_shreg = {shreg[lrxd_pkg::WORD_MAX-3:0], rx_sync[1], rx_sync[0]};
         end else begin
            next_shreg = {shreg[lrxd_pkg::WORD_MAX-2:0], rx_sync[1]};
         end
         strobe     = phase == LAST;
         next_phase = strobe ? lrxd_pkg::PHASE_RESET : 4'(phase + 4'h1);
      end
   end

   // Shift register and word phase.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         shreg <= '0;
         phase <= lrxd_pkg::PHASE_RESET;
      end else begin
         shreg <= next_shreg;
         phase <= next_phase;
      end
   end

   // ----------------------------------------
   // Word hand-off
   // ----------------------------------------
   // one word per word period
   // The word is masked to the width in effect; illegal settings send nothing.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         word <= '0;
      end else begin
         word.valid <= CFG_OK && strobe;
         if (strobe) begin
            word.data <= next_shreg & MASK;
         end
      end
   end

   // narrow widths keep it
   // Word clock is high in the first half, rounded up, of each word period longer than one cycle.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         parallel_word_clock <= lrxd_pkg::PWC_RESET;
      end else if (CYC == 4'h1) begin
         parallel_word_clock <= !parallel_word_clock;
      end else begin
         parallel_word_clock <= next_phase < PWC_HIGH;
      end
   end

   // flag bad settings
   // Settings are rechecked each cycle so software can see a bad lane.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cfg_error <= lrxd_pkg::FLAG_RESET;
      end else begin
         cfg_error <= !CFG_OK;
      end
   end

   // ----------------------------------------
   // Single-clock FIFO toward the core
   // ----------------------------------------
   // FIFO only when allowed
   lrxd_fifo #(
      .WIDTH(lrxd_pkg::WORD_MAX),
      .DEPTH(lrxd_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock    (clock),
      .rstn     (rstn),
      .in_valid (word.valid && FIFO_ON),
      .in_ready (fifo_in_ready),
      .in_data  (word.data),
      .out_ready(fifo_read_request && FIFO_ON),
      .out_empty(fifo_empty),
      .out_valid(fifo_out_valid),
      .out_data (fifo_out_data)
   );

   assign fifo_read_word = '{valid: fifo_out_valid, data: fifo_out_data};

   // Space report and a sticky flag for words lost on a full FIFO.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lane_ready <= lrxd_pkg::READY_RESET;
         overrun    <= lrxd_pkg::FLAG_RESET;
      end else begin
         lane_ready <= fifo_in_ready;
         if (word.valid && FIFO_ON && !fifo_in_ready) begin
            overrun <= 1'h1;
         end
      end
   end

   // ----------------------------------------
   // Assertion helpers
   // ----------------------------------------
   logic [4:0] gap;
   logic       seen;
   logic       slip_seen;

   // Cycles since the last word, and whether a slip fell inside that span.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         gap       <= '0;
         seen      <= lrxd_pkg::FLAG_RESET;
         slip_seen <= lrxd_pkg::FLAG_RESET;
      end else begin
         if (word.valid) begin
            gap       <= 5'h01;
            seen      <= 1'h1;
            slip_seen <= slip_hold;
         end else begin
            if (gap != 5'h1F) gap <= 5'(gap + 5'h01);
            if (slip_hold) slip_seen <= 1'h1;
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence s_read_empty;
      fifo_read_request && fifo_empty;
   endsequence

   sequence s_word_out;
      word.valid && seen && !slip_seen;
   endsequence

   property p_width_nine;
      CFG.des_en && CFG.width == lrxd_pkg::WIDTH_BAD |=> cfg_error && !word.valid;
   endproperty
   a_width_nine: assert property (p_width_nine) else $error("width nine not refused");

   property p_dpa_half;
      CFG.dpa && CFG.half_rate |=> cfg_error;
   endproperty
   a_dpa_half: assert property (p_dpa_half) else $error("half rate with alignment");

   property p_dpa_bypass;
      CFG.dpa && !CFG.des_en |=> cfg_error;
   endproperty
   a_dpa_bypass: assert property (p_dpa_bypass) else $error("alignment in bypass");

   property p_dpa_narrow;
      CFG.dpa && CFG.width <= lrxd_pkg::WIDTH_NARROW_MAX |=> cfg_error;
   endproperty
   a_dpa_narrow: assert property (p_dpa_narrow) else $error("alignment below width 3");

   property p_fifo_narrow;
      CFG.fifo_en && (!CFG.des_en || CFG.width <= lrxd_pkg::WIDTH_NARROW_MAX)
         |=> cfg_error && !fifo_read_word.valid;
   endproperty
   a_fifo_narrow: assert property (p_fifo_narrow) else $error("FIFO on narrow lane");

   property p_half_odd;
      CFG.half_rate && CFG.width[0] |=> cfg_error;
   endproperty
   a_half_odd: assert property (p_half_odd) else $error("half rate with odd width");

   property p_word_range;
      word.valid |-> (word.data & ~MASK) == '0 && CFG.width != lrxd_pkg::WIDTH_BAD;
   endproperty
   a_word_range: assert property (p_word_range) else $error("word wider than lane");

   property p_capture;
      word.valid |-> word.data[0] == (HALF ? $past(rx_sync[0]) : $past(rx_sync[1]));
   endproperty
   a_capture: assert property (p_capture) else $error("newest bit not in word");

   property p_no_empty_read;
      s_read_empty |=> !fifo_read_word.valid;
   endproperty
   a_no_empty_read: assert property (p_no_empty_read) else $error("read while empty");

   property p_word_gap;
      s_word_out |-> gap == {1'h0, CYC};
   endproperty
   a_word_gap: assert property (p_word_gap) else $error("word spacing wrong");

   property p_pwc_runs;
      CFG_OK && CYC > 4'h1 |-> ##[1:20] $changed(parallel_word_clock);
   endproperty
   a_pwc_runs: assert property (p_pwc_runs) else $error("word clock stalled");

endmodule
`default_nettype wire

// ==== dv/lrxd_tx_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lrxd_tx_model #(
   parameter logic [7:0] TRAIN = 8'h01,
   parameter bit         PAIR  = 1'h0
) (
   input  wire logic       clock,
   input  wire logic       rstn,
   output logic      [1:0] rx_bits
);

   // ----------------------------------------
   // Transmit state
   // ----------------------------------------
   logic [7:0] tx_q[$];   // Bytes waiting to be sent, oldest first.
   logic [7:0] cur;       // Byte on the line.
   int         idx;       // Bit of cur sent next, most significant first.

   // One bit leaves per serial clock at full rate; at half rate two leave, older on pin one.
   // Training bytes fill every gap, which keeps the line busy and lets the receiver align.
   // The model sees only the serial clock; the word clock is made inside the lane.
   // shared clock, bit rate
   always @(posedge clock) begin
      if (!rstn) begin
         idx = 7;
         cur = TRAIN;
         rx_bits <= 2'h0;
      end else begin
         if (idx == 7) begin
            cur = (tx_q.size() != 0) ? tx_q.pop_front() : TRAIN;
         end
         if (PAIR) begin
            rx_bits <= {cur[idx], cur[idx-1]};
         end else begin
            rx_bits <= {2{cur[idx]}};
         end
         idx = (idx <= int'(PAIR)) ? 7 : idx - 1 - int'(PAIR);
      end
   end

endmodule
`default_nettype wire

// ==== dv/lrxd_lane_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module lrxd_lane_test;

   // ----------------------------------------
   // Configuration, signals and instances
   // ----------------------------------------
   localparam logic [7:0] TRAIN = 8'h01;
   localparam lrxd_pkg::lrxd_cfg_t TB_CFG = '{des_en: 1'h1, width: 4'h8, half_rate: 1'h0,
                                              dpa: 1'h1, fifo_en: 1'h1};
   localparam lrxd_pkg::lrxd_cfg_t HALF_CFG = '{des_en: 1'h1, width: 4'hA, half_rate: 1'h1,
                                                dpa: 1'h0, fifo_en: 1'h0};

   logic                 clock;
   logic                 rstn;
   logic [1:0]           rx_bits;
   logic                 dpa_slip;
   logic                 parallel_word_clock;
   lrxd_pkg::lrxd_word_t word_out;
   logic                 fifo_read_request;
   logic                 fifo_empty;
   lrxd_pkg::lrxd_word_t fifo_word;
   logic                 lane_ready;
   logic                 overrun;
   logic                 cfg_error;
   logic [1:0]           half_bits;
   lrxd_pkg::lrxd_word_t half_word;
   int                   fails;
   int                   total_checks;
   logic [9:0]           d;
   int                   n;

   lrxd_tx_model #(.TRAIN(TRAIN)) model (.clock(clock), .rstn(rstn), .rx_bits(rx_bits));

   // A second lane at half rate sees a steady one-zero pair on every clock.
   lrxd_tx_model #(.TRAIN(8'hAA), .PAIR(1'h1)) half_model (.clock(clock), .rstn(rstn),
                                                          .rx_bits(half_bits));

   lrxd_lane #(.CFG(TB_CFG)) uut (
      .clock               (clock),
      .rstn                (rstn),
      .rx_bits             (rx_bits),
      .dpa_slip            (dpa_slip),
      .parallel_word_clock (parallel_word_clock),
      .word                (word_out),
      .fifo_read_request   (fifo_read_request),
      .fifo_empty          (fifo_empty),
      .fifo_read_word      (fifo_word),
      .lane_ready          (lane_ready),
      .overrun             (overrun),
      .cfg_error           (cfg_error)
   );

   lrxd_lane #(.CFG(HALF_CFG)) uut_half (
      .clock               (clock),
      .rstn                (rstn),
      .rx_bits             (half_bits),
      .dpa_slip            (dpa_slip),
      .parallel_word_clock (),
      .word                (half_word),
      .fifo_read_request   (fifo_read_request),
      .fifo_empty          (),
      .fifo_read_word      (),
      .lane_ready          (),
      .overrun             (),
      .cfg_error           ()
   );

   // The clock toggles every half period of 5 ns.
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end

   // ----------------------------------------
   // Compare and closing tasks
   // ----------------------------------------
   // Compares one flag and counts the result.
   task automatic check_bit(input string name, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %b seen %b", name, exp, got);
      end
   endtask

   // Compares one ten-bit word and counts the result.
   task automatic check_word(input string name, input logic [9:0] exp, input logic [9:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Prints the counts and the verdict, then stops the run.
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   // Waits, at falling edges, for the next word pulse and returns its data.
   task automatic get_word(output logic [9:0] data);
      int k;
      data = 10'h3FF;
      for (k = 0; k < 40; k++) begin
         @(negedge clock);
         if (word_out.valid === 1'h1) begin
            data = word_out.data;
            break;
         end
      end
      check_bit("word pulse seen", 1'h1, word_out.valid);
   endtask

   // Waits, at falling edges, for the next read answer and returns its data.
   task automatic get_read(output logic [9:0] data);
      int k;
      data = 10'h3FF;
      for (k = 0; k < 4; k++) begin
         @(negedge clock);
         if (fifo_word.valid === 1'h1) begin
            data = fifo_word.data;
            break;
         end
      end
      check_bit("read answer seen", 1'h1, fifo_word.valid);
   endtask

   // Slips one bit at a time until the training byte appears on the word output.
   task automatic align;
      int k;
      for (k = 0; k < 10; k++) begin
         get_word(d);
         get_word(d);
         if (d === {2'h0, TRAIN}) begin
            break;
         end
         @(posedge clock) dpa_slip <= 1'h1;
         @(posedge clock) dpa_slip <= 1'h0;
      end
   endtask

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      fails = 0;
      total_checks = 0;
      rstn = 1'h0;
      dpa_slip = 1'h0;
      fifo_read_request = 1'h1;
      repeat (2) @(negedge clock);
      check_bit("reset word valid", 1'h0, word_out.valid);
      check_bit("reset fifo empty", 1'h1, fifo_empty);
      check_bit("reset lane ready", 1'h1, lane_ready);
      check_bit("reset overrun", 1'h0, overrun);
      check_bit("reset word clock", 1'h0, parallel_word_clock);
      repeat (2) @(posedge clock);
      rstn <= 1'h1;
      // Reads on an empty buffer must produce no answer.
      repeat (5) begin
         @(negedge clock);
         check_bit("read while empty", 1'h0, fifo_word.valid);
      end
      check_bit("legal config flag", 1'h0, cfg_error);
      align();
      check_word("aligned word", {2'h0, TRAIN}, d);
      // The word clock is high for half of each eight-cycle word period.
      n = 0;
      repeat (32) begin
         @(negedge clock);
         n += (parallel_word_clock === 1'h1) ? 1 : 0;
      end
      check_word("word clock high cycles", 10'h010, 10'(n));
      // Sixteen distinct bytes; reads stop as the first one reaches the buffer.
      for (n = 0; n < 16; n++) begin
         model.tx_q.push_back(8'hC0 + 8'(n));
      end
      n = 0;
      do begin
         get_word(d);
         n++;
      end while (d === {2'h0, TRAIN} && n < 6);
      @(posedge clock) fifo_read_request <= 1'h0;
      check_word("first payload word", {2'h0, 8'hC0}, d);
      for (n = 1; n < 16; n++) begin
         get_word(d);
         check_word("payload word", {2'h0, 8'hC0 + 8'(n)}, d);
      end
      // The next training word finds the buffer full and is lost.
      get_word(d);
      repeat (2) @(negedge clock);
      check_bit("lane ready when full", 1'h0, lane_ready);
      check_bit("overrun after loss", 1'h1, overrun);
      check_bit("fifo empty when full", 1'h0, fifo_empty);
      // Back-to-back reads drain the payload in order.
      @(posedge clock) fifo_read_request <= 1'h1;
      for (n = 0; n < 16; n++) begin
         get_read(d);
         check_word("buffered word", {2'h0, 8'hC0 + 8'(n)}, d);
      end
      n = 0;
      while (fifo_empty !== 1'h1 && n < 20) begin
         @(negedge clock);
         n++;
      end
      check_bit("fifo drained", 1'h1, fifo_empty);
      check_bit("overrun sticky", 1'h1, overrun);
      check_bit("config still legal", 1'h0, cfg_error);
      // Half-rate lane: pin one holds the older bit, so each word reads one-zero pairs.
      n = 0;
      while (half_word.valid !== 1'h1 && n < 20) begin
         @(negedge clock);
         n++;
      end
      check_bit("half rate pulse", 1'h1, half_word.valid);
      check_word("half rate word", 10'h2AA, half_word.data);
      // Ten bits two at a time give a word every five cycles.
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (half_word.valid !== 1'h1 && n < 20);
      check_word("half rate word period", 10'h005, 10'(n));
      // A second reset clears the sticky loss flag and empties the buffer.
      @(posedge clock) rstn <= 1'h0;
      repeat (2) @(negedge clock);
      check_bit("overrun after reset", 1'h0, overrun);
      check_bit("fifo empty after reset", 1'h1, fifo_empty);
      check_bit("word valid in reset", 1'h0, word_out.valid);
      @(posedge clock) rstn <= 1'h1;
      get_word(d);
      check_bit("config legal after reset", 1'h0, cfg_error);
      end_of_test();
   end

   // Stops a hung run well beyond the few hundred cycles the tests need.
   initial begin
      repeat (5000) @(posedge clock);
      fails++;
      end_of_test();
   end

endmodule
`default_nettype wire
